// >>> hdl/ctr_readout.sv
// Current and thermistor measurement readout with bias control and temperature reporting.
`include "ctr_consts.svh"

module ctr_readout #(
    parameter int unsigned BASE_WINDOW_CYCLES = `CTR_BASE_WINDOW_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [11:0] aux_fast_current_code,
    input  wire logic        aux_fast_current_valid,
    input  wire logic [11:0] fast_current_sense_a_code,
    input  wire logic        fast_current_sense_a_valid,
    input  wire logic [11:0] fast_current_sense_b_code,
    input  wire logic        fast_current_sense_b_valid,
    input  wire logic [11:0] precise_current_sense_a_code,
    input  wire logic        precise_current_sense_a_valid,
    input  wire logic [11:0] precise_current_sense_b_code,
    input  wire logic        precise_current_sense_b_valid,
    input  wire logic [11:0] thermistor_input_one_code,
    input  wire logic        thermistor_input_one_valid,
    input  wire logic [11:0] thermistor_input_two_code,
    input  wire logic        thermistor_input_two_valid,
    input  wire logic [15:0] pmbus_cmd,
    input  wire logic        pmbus_wr_en,
    input  wire logic [7:0]  pmbus_wr_data,
    input  wire logic        pmbus_rd_en,
    output logic [15:0]      pmbus_rd_data,
    output logic             pmbus_rd_valid,
    output logic             pmbus_cmd_err,
    output logic [1:0]       thermistor_one_bias_sel,
    output logic [5:0]       thermistor_one_bias_trim,
    output logic [8:0]       thermistor_one_bias_steps,
    output logic [1:0]       thermistor_two_bias_sel,
    output logic [5:0]       thermistor_two_bias_trim,
    output logic [8:0]       thermistor_two_bias_steps,
    output logic [11:0]      thermistor_one_otp_code,
    output logic [11:0]      thermistor_two_otp_code,
    output logic             current_window_end
);

    // ****************************************************************
    // Channel map: 0..4 are currents, 5..6 are thermistors
    // ****************************************************************
    localparam int NUM_CH   = 7;
    localparam int TH_FIRST = 5;

    ctr_pkg::ctr_main_state_t st_ff;
    ctr_pkg::ctr_main_state_t nxt_st;

    logic [NUM_CH-1:0][11:0] ch_code;
    logic [NUM_CH-1:0]       ch_valid;
    logic [NUM_CH-1:0]       ch_win_end;
    logic [NUM_CH-1:0][11:0] ch_avg;
    logic [NUM_CH-1:0]       ch_avg_valid;
    logic [1:0][9:0]         temp_deg;
    logic                    base_end;
    logic                    cur_end;
    ctr_pkg::ctr_reg_t       wr_sel;
    ctr_pkg::ctr_reg_t       rd_sel;

    // ****************************************************************
    // Functions
    // ****************************************************************

    // The converter may exceed the valid input range; the code is pinned at the maximum.
    function automatic logic [11:0] clamp_therm(input logic [11:0] code);
        return (code > `CTR_THERM_CODE_MAX) ? `CTR_THERM_CODE_MAX : code;
    endfunction : clamp_therm

    // Bias in 156.25 nA steps: one base step is 64 trim steps, trim only adds.
    function automatic logic [8:0] bias_steps(input logic [7:0] bias);
        logic [8:0] base;
        base = 9'(bias[`CTR_BIAS_SEL_MSB:`CTR_BIAS_SEL_LSB]) + 9'h1;
        return 9'(base * `CTR_TRIM_STEPS_PER_BASE)
               + 9'(bias[`CTR_BIAS_TRIM_MSB:`CTR_BIAS_TRIM_LSB]);
    endfunction : bias_steps

    function automatic logic [4:0] rate_windows(input ctr_pkg::ctr_rate_t rate);
        logic [4:0] n;
        unique case (rate)
            ctr_pkg::CTR_RATE_10MS:  n = 5'(`CTR_RATE_10MS_MS / `CTR_BASE_WINDOW_MS);
            ctr_pkg::CTR_RATE_50MS:  n = 5'(`CTR_RATE_50MS_MS / `CTR_BASE_WINDOW_MS);
            ctr_pkg::CTR_RATE_100MS: n = 5'(`CTR_RATE_100MS_MS / `CTR_BASE_WINDOW_MS);
            ctr_pkg::CTR_RATE_200MS: n = 5'(`CTR_RATE_200MS_MS / `CTR_BASE_WINDOW_MS);
        endcase
        return n;
    endfunction : rate_windows

    // Shared by the read and write paths so both see one address map.
    function automatic ctr_pkg::ctr_reg_t decode(input logic [15:0] cmd);
        ctr_pkg::ctr_reg_t r;
        unique case (cmd)
            `CTR_OFS_THERM1_BIAS:  r = ctr_pkg::CTR_REG_THERM1_BIAS;
            `CTR_OFS_THERM2_BIAS:  r = ctr_pkg::CTR_REG_THERM2_BIAS;
            `CTR_OFS_CUR_RATE:     r = ctr_pkg::CTR_REG_CUR_RATE;
            `CTR_OFS_AUX_FAST:     r = ctr_pkg::CTR_REG_AUX_FAST;
            `CTR_OFS_FAST_A:       r = ctr_pkg::CTR_REG_FAST_A;
            `CTR_OFS_FAST_B:       r = ctr_pkg::CTR_REG_FAST_B;
            `CTR_OFS_PRECISE_A:    r = ctr_pkg::CTR_REG_PRECISE_A;
            `CTR_OFS_PRECISE_B:    r = ctr_pkg::CTR_REG_PRECISE_B;
            `CTR_OFS_THERM1_RAW:   r = ctr_pkg::CTR_REG_THERM1_RAW;
            `CTR_OFS_THERM2_RAW:   r = ctr_pkg::CTR_REG_THERM2_RAW;
            `CTR_CMD_READ_TEMP_1:  r = ctr_pkg::CTR_REG_TEMP_1;
            `CTR_CMD_READ_TEMP_2:  r = ctr_pkg::CTR_REG_TEMP_2;
            default:               r = ctr_pkg::CTR_REG_NONE;
        endcase
        return r;
    endfunction : decode

    // The temperature word: zero exponent, zero sign, whole degrees below.
    function automatic logic [15:0] temp_word(input logic [9:0] deg);
        return {`CTR_LIN_EXPONENT, `CTR_LIN_SIGN, deg};
    endfunction : temp_word

    // ****************************************************************
    // Sample routing
    // ****************************************************************
    // Current codes pass unscaled: the code already is the input voltage over the step.
    assign ch_code[0]  = aux_fast_current_code;
    assign ch_code[1]  = fast_current_sense_a_code;
    assign ch_code[2]  = fast_current_sense_b_code;
    assign ch_code[3]  = precise_current_sense_a_code;
    assign ch_code[4]  = precise_current_sense_b_code;
    assign ch_code[5]  = clamp_therm(thermistor_input_one_code);
    assign ch_code[6]  = clamp_therm(thermistor_input_two_code);
    assign ch_valid[0] = aux_fast_current_valid;
    assign ch_valid[1] = fast_current_sense_a_valid;
    assign ch_valid[2] = fast_current_sense_b_valid;
    assign ch_valid[3] = precise_current_sense_a_valid;
    assign ch_valid[4] = precise_current_sense_b_valid;
    assign ch_valid[5] = thermistor_input_one_valid;
    assign ch_valid[6] = thermistor_input_two_valid;

    // ****************************************************************
    // Window timing
    // ****************************************************************
    assign base_end = (st_ff.base_cnt == 24'(BASE_WINDOW_CYCLES - 1));
    // Greater-or-equal lets a shortened rate take effect without waiting for a wrap.
    assign cur_end  = base_end
                      && (st_ff.win_cnt + 5'h1
                          >= rate_windows(ctr_pkg::ctr_rate_t'(st_ff.rate[1:0])));

    // ****************************************************************
    // Averagers and linearizers
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_avg
            // Thermistors keep the fixed base window whatever the current rate is.
            assign ch_win_end[g] = (g >= TH_FIRST) ? base_end : cur_end;
            ctr_averager u_avg (
                .core_clk     (core_clk),
                .reset        (reset),
                .sample_valid (ch_valid[g]),
                .sample       (ch_code[g]),
                .window_end   (ch_win_end[g]),
                .avg_valid    (ch_avg_valid[g]),
                .avg          (ch_avg[g])
            );
        end
        for (g = 0; g < 2; g++) begin : g_lin
            ctr_temp_lin u_lin (
                .core_clk (core_clk),
                .reset    (reset),
                .raw_code (st_ff.val[TH_FIRST+g]),
                .temp_deg (temp_deg[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Next state
    // ****************************************************************
    assign wr_sel = decode(pmbus_cmd);
    assign rd_sel = wr_sel;

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.base_cnt = base_end ? '0 : st_ff.base_cnt + 24'h1;
        if (base_end) begin
            nxt_st.win_cnt = cur_end ? '0 : st_ff.win_cnt + 5'h1;
        end

        // A whole 12-bit value lands in one edge; raw thermistor codes stay linear.
        for (int i = 0; i < NUM_CH; i++) begin
            if (ch_avg_valid[i]) begin
                nxt_st.val[i] = ch_avg[i];
            end
        end

        nxt_st.cmd_err = 1'b0;
        if (pmbus_wr_en) begin
            unique case (wr_sel)
                ctr_pkg::CTR_REG_THERM1_BIAS: nxt_st.bias_one = pmbus_wr_data;
                ctr_pkg::CTR_REG_THERM2_BIAS: nxt_st.bias_two = pmbus_wr_data;
                ctr_pkg::CTR_REG_CUR_RATE: begin
                    nxt_st.rate = {6'h00,
                        pmbus_wr_data[`CTR_RATE_SEL_MSB:`CTR_RATE_SEL_LSB]};
                end
                default: nxt_st.cmd_err = 1'b1;
            endcase
        end

        nxt_st.rd_valid = pmbus_rd_en;
        if (pmbus_rd_en) begin
            nxt_st.rd_data = '0;
            unique case (rd_sel)
                ctr_pkg::CTR_REG_THERM1_BIAS: nxt_st.rd_data = {8'h00, st_ff.bias_one};
                ctr_pkg::CTR_REG_THERM2_BIAS: nxt_st.rd_data = {8'h00, st_ff.bias_two};
                ctr_pkg::CTR_REG_CUR_RATE:    nxt_st.rd_data = {8'h00, st_ff.rate};
                ctr_pkg::CTR_REG_AUX_FAST:    nxt_st.rd_data = {4'h0, st_ff.val[0]};
                ctr_pkg::CTR_REG_FAST_A:      nxt_st.rd_data = {4'h0, st_ff.val[1]};
                ctr_pkg::CTR_REG_FAST_B:      nxt_st.rd_data = {4'h0, st_ff.val[2]};
                ctr_pkg::CTR_REG_PRECISE_A:   nxt_st.rd_data = {4'h0, st_ff.val[3]};
                ctr_pkg::CTR_REG_PRECISE_B:   nxt_st.rd_data = {4'h0, st_ff.val[4]};
                ctr_pkg::CTR_REG_THERM1_RAW:  nxt_st.rd_data = {4'h0, st_ff.val[5]};
                ctr_pkg::CTR_REG_THERM2_RAW:  nxt_st.rd_data = {4'h0, st_ff.val[6]};
                ctr_pkg::CTR_REG_TEMP_1:      nxt_st.rd_data = temp_word(temp_deg[0]);
                ctr_pkg::CTR_REG_TEMP_2:      nxt_st.rd_data = temp_word(temp_deg[1]);
                default:                      nxt_st.cmd_err = 1'b1;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff          <= '0;
            st_ff.bias_one <= `CTR_BIAS_RESET;
            st_ff.bias_two <= `CTR_BIAS_RESET;
            st_ff.rate     <= `CTR_RATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pmbus_rd_data             = st_ff.rd_data;
    assign pmbus_rd_valid            = st_ff.rd_valid;
    assign pmbus_cmd_err             = st_ff.cmd_err;
    assign thermistor_one_bias_sel   = st_ff.bias_one[`CTR_BIAS_SEL_MSB:`CTR_BIAS_SEL_LSB];
    assign thermistor_one_bias_trim  = st_ff.bias_one[`CTR_BIAS_TRIM_MSB:`CTR_BIAS_TRIM_LSB];
    assign thermistor_one_bias_steps = bias_steps(st_ff.bias_one);
    assign thermistor_two_bias_sel   = st_ff.bias_two[`CTR_BIAS_SEL_MSB:`CTR_BIAS_SEL_LSB];
    assign thermistor_two_bias_trim  = st_ff.bias_two[`CTR_BIAS_TRIM_MSB:`CTR_BIAS_TRIM_LSB];
    assign thermistor_two_bias_steps = bias_steps(st_ff.bias_two);
    // Protection sees the same averaged, clamped code as the monitoring path.
    assign thermistor_one_otp_code   = st_ff.val[TH_FIRST];
    assign thermistor_two_otp_code   = st_ff.val[TH_FIRST + 1];
    assign current_window_end        = cur_end;

endmodule : ctr_readout

// >>> hdl/ctr_consts.svh
// Offsets, field positions, reset values and timing counts of the readout block.
`ifndef CTR_CONSTS_SVH
`define CTR_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CTR_CLK_PERIOD_NS       8
`define CTR_NS_PER_MS           1_000_000
`define CTR_BASE_WINDOW_MS      10
`define CTR_BASE_WINDOW_CYCLES  (`CTR_BASE_WINDOW_MS * `CTR_NS_PER_MS / `CTR_CLK_PERIOD_NS)
`define CTR_RATE_10MS_MS        10
`define CTR_RATE_50MS_MS        50
`define CTR_RATE_100MS_MS       100
`define CTR_RATE_200MS_MS       200

// ****************************************************************
// Register and command addresses
// ****************************************************************
`define CTR_OFS_THERM1_BIAS     16'hfe80
`define CTR_OFS_THERM2_BIAS     16'hfe81
`define CTR_OFS_CUR_RATE        16'hfe89
`define CTR_OFS_AUX_FAST        16'hfed0
`define CTR_OFS_FAST_A          16'hfed1
`define CTR_OFS_FAST_B          16'hfed2
`define CTR_OFS_PRECISE_A       16'hfed3
`define CTR_OFS_PRECISE_B       16'hfed4
`define CTR_OFS_THERM1_RAW      16'hfed7
`define CTR_OFS_THERM2_RAW      16'hfed8
`define CTR_CMD_READ_TEMP_1     16'h008d
`define CTR_CMD_READ_TEMP_2     16'h008e

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTR_BIAS_SEL_MSB        7
`define CTR_BIAS_SEL_LSB        6
`define CTR_BIAS_TRIM_MSB       5
`define CTR_BIAS_TRIM_LSB       0
`define CTR_RATE_SEL_MSB        1
`define CTR_RATE_SEL_LSB        0
`define CTR_BIAS_RESET          8'he6
`define CTR_RATE_RESET          8'h00
`define CTR_TRIM_STEPS_PER_BASE 9'h040
`define CTR_THERM_CODE_MAX      12'hccd
`define CTR_LIN_EXPONENT        5'h00
`define CTR_LIN_SIGN            1'b0
`define CTR_LIN_STEP_DEG        20

`endif

// >>> hdl/ctr_pkg.sv
// Types shared by the current and temperature readout modules.
package ctr_pkg;

    typedef enum logic [1:0] {
        CTR_RATE_10MS,
        CTR_RATE_50MS,
        CTR_RATE_100MS,
        CTR_RATE_200MS
    } ctr_rate_t;

    typedef enum logic [3:0] {
        CTR_REG_NONE,
        CTR_REG_THERM1_BIAS,
        CTR_REG_THERM2_BIAS,
        CTR_REG_CUR_RATE,
        CTR_REG_AUX_FAST,
        CTR_REG_FAST_A,
        CTR_REG_FAST_B,
        CTR_REG_PRECISE_A,
        CTR_REG_PRECISE_B,
        CTR_REG_THERM1_RAW,
        CTR_REG_THERM2_RAW,
        CTR_REG_TEMP_1,
        CTR_REG_TEMP_2
    } ctr_reg_t;

    typedef struct packed {
        logic [36:0] sum;
        logic [24:0] cnt;
        logic [11:0] avg;
        logic        avg_valid;
    } ctr_avg_state_t;

    typedef struct packed {
        logic [9:0] temp;
    } ctr_lin_state_t;

    typedef struct packed {
        logic [7:0]       bias_one;
        logic [7:0]       bias_two;
        logic [7:0]       rate;
        logic [23:0]      base_cnt;
        logic [4:0]       win_cnt;
        logic [6:0][11:0] val;
        logic [15:0]      rd_data;
        logic             rd_valid;
        logic             cmd_err;
    } ctr_main_state_t;

endpackage : ctr_pkg

// >>> hdl/ctr_averager.sv
// Window averager: sums samples over a window and publishes the mean at its end.
module ctr_averager (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        sample_valid,
    input  wire logic [11:0] sample,
    input  wire logic        window_end,
    output logic             avg_valid,
    output logic [11:0]      avg
);

    ctr_pkg::ctr_avg_state_t st_ff;
    ctr_pkg::ctr_avg_state_t nxt_st;

    // A sample arriving on the closing cycle opens the next window, so none is lost.
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.avg_valid = 1'b0;
        if (window_end) begin
            if (st_ff.cnt != '0) begin
                nxt_st.avg       = 12'(st_ff.sum / 37'(st_ff.cnt));
                nxt_st.avg_valid = 1'b1;
            end
            nxt_st.sum = sample_valid ? 37'(sample) : '0;
            nxt_st.cnt = sample_valid ? 25'h1 : '0;
        end else if (sample_valid) begin
            nxt_st.sum = st_ff.sum + 37'(sample);
            nxt_st.cnt = st_ff.cnt + 25'h1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avg_valid = st_ff.avg_valid;
    assign avg       = st_ff.avg;

endmodule : ctr_averager

// >>> hdl/ctr_temp_lin.sv
// Piecewise-linear conversion of a thermistor code to whole degrees Celsius.
`include "ctr_consts.svh"

module ctr_temp_lin (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [11:0] raw_code,
    output logic [9:0]       temp_deg
);

    // Codes at 0, 20, ... 140 degC for the fixed bias and parallel resistor network.
    localparam logic [11:0] CODE_AT [0:7] = '{12'h743, 12'h6b8, 12'h5b9, 12'h45f,
                                              12'h303, 12'h1f3, 12'h13b, 12'h0c8};

    ctr_pkg::ctr_lin_state_t st_ff;
    ctr_pkg::ctr_lin_state_t nxt_st;

    // Codes above the 0 degC point clamp to zero; no negative reading is produced.
    always_comb begin
        int unsigned deg;
        deg = 0;
        if (raw_code < CODE_AT[7]) begin
            deg = 7 * `CTR_LIN_STEP_DEG;
        end
        for (int i = 0; i < 7; i++) begin
            if (raw_code < CODE_AT[i] && raw_code >= CODE_AT[i+1]) begin
                deg = i * `CTR_LIN_STEP_DEG
                      + `CTR_LIN_STEP_DEG * 32'(CODE_AT[i] - raw_code)
                        / 32'(CODE_AT[i] - CODE_AT[i+1]);
            end
        end
        nxt_st.temp = 10'(deg);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign temp_deg = st_ff.temp;

endmodule : ctr_temp_lin

// >>> tb/ctr_readout_assertions.sv
// Port-level checks of the readout block.
module ctr_readout_assertions #(
    parameter int unsigned BASE_WINDOW_CYCLES = 1_250_000
) (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic [15:0] pmbus_cmd,
    input wire logic        pmbus_rd_en,
    input wire logic [15:0] pmbus_rd_data,
    input wire logic        pmbus_rd_valid,
    input wire logic [1:0]  thermistor_one_bias_sel,
    input wire logic [5:0]  thermistor_one_bias_trim,
    input wire logic [8:0]  thermistor_one_bias_steps,
    input wire logic [11:0] thermistor_one_otp_code,
    input wire logic        current_window_end
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_rd_ans; pmbus_rd_en |=> pmbus_rd_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rd_quiet; !pmbus_rd_en |=> !pmbus_rd_valid; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read answer");
    property p_hold; !pmbus_rd_valid |-> $stable(pmbus_rd_data); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_steps;
        thermistor_one_bias_steps ==
            {3'(thermistor_one_bias_sel) + 3'h1, thermistor_one_bias_trim};
    endproperty
    a_steps: assert property (p_steps) else $error("bias steps wrong");
    property p_clamp; thermistor_one_otp_code <= 12'hccd; endproperty
    a_clamp: assert property (p_clamp) else $error("code above limit");
    property p_word; pmbus_rd_en && pmbus_cmd == 16'h008d |=> pmbus_rd_data[15:10] == 6'h00;
    endproperty
    a_word: assert property (p_word) else $error("temperature word format");
    property p_deg; pmbus_rd_en && pmbus_cmd == 16'h008e |=> pmbus_rd_data <= 16'h008c;
    endproperty
    a_deg: assert property (p_deg) else $error("temperature out of range");
    property p_raw; pmbus_rd_en && pmbus_cmd == 16'hfed7 |=> pmbus_rd_data <= 16'h0ccd;
    endproperty
    a_raw: assert property (p_raw) else $error("raw value format");
    property p_win; current_window_end |=> !current_window_end [*8]; endproperty
    a_win: assert property (p_win) else $error("refresh too soon");
endmodule : ctr_readout_assertions

// >>> tb/ctr_host.sv
// Management host model issuing single register and command accesses.
module ctr_host (
    input  wire logic        core_clk,
    input  wire logic [15:0] pmbus_rd_data,
    input  wire logic        pmbus_rd_valid,
    input  wire logic        pmbus_cmd_err,
    output logic      [15:0] pmbus_cmd,
    output logic             pmbus_wr_en,
    output logic      [7:0]  pmbus_wr_data,
    output logic             pmbus_rd_en
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {pmbus_cmd, pmbus_wr_en, pmbus_wr_data, pmbus_rd_en} = '0;
    end
    // ****************************************************************
    // Access task
    // ****************************************************************
    // Released command and data lines carry the inverse so a stale value is never mistaken for a request.
    task automatic access(input logic [15:0] cmd, input logic wr, input logic [7:0] data,
                          output logic [15:0] rd, output logic err);
        @(negedge core_clk);
        pmbus_cmd     = cmd;
        pmbus_wr_data = data;
        pmbus_wr_en   = wr;
        pmbus_rd_en   = !wr;
        @(negedge core_clk);
        rd            = pmbus_rd_valid ? pmbus_rd_data : 16'hxxxx;
        err           = pmbus_cmd_err;
        pmbus_wr_en   = 1'b0;
        pmbus_rd_en   = 1'b0;
        pmbus_cmd     = ~cmd;
        pmbus_wr_data = ~data;
    endtask : access
endmodule : ctr_host

// >>> tb/tb_ctr_readout.sv
// Self-checking bench of the readout block driven through the host model.
bind ctr_readout ctr_readout_assertions #(.BASE_WINDOW_CYCLES(BASE_WINDOW_CYCLES)) u_chk (
    .core_clk(core_clk), .reset(reset), .pmbus_cmd(pmbus_cmd), .pmbus_rd_en(pmbus_rd_en),
    .pmbus_rd_data(pmbus_rd_data), .pmbus_rd_valid(pmbus_rd_valid),
    .thermistor_one_bias_sel(thermistor_one_bias_sel),
    .thermistor_one_bias_trim(thermistor_one_bias_trim),
    .thermistor_one_bias_steps(thermistor_one_bias_steps),
    .thermistor_one_otp_code(thermistor_one_otp_code), .current_window_end(current_window_end));
module tb_ctr_readout;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned BW = 50;
    typedef struct packed {logic [15:0] cmd; logic [7:0] wd; logic [15:0] exp; logic [8:0] stp;}
        ctr_row_t;
    ctr_row_t rows [5] = '{'{16'hfe80, 8'h3f, 16'h003f, 9'h07f}, '{16'hfe80, 8'h40, 16'h0040,
        9'h080}, '{16'hfe81, 8'h80, 16'h0080, 9'h0c0}, '{16'hfe81, 8'hff, 16'h00ff, 9'h13f},
        '{16'hfe89, 8'hff, 16'h0003, 9'h000}};
    logic [15:0] adr [9] = '{16'hfed0, 16'hfed1, 16'hfed2, 16'hfed3, 16'hfed4, 16'hfed7,
        16'hfed8, 16'h008d, 16'h008e};
    logic [15:0] vex [9] = '{16'h0a00, 16'h0fff, 16'h0000, 16'h0555, 16'h0fff, 16'h0ccd,
        16'h045f, 16'h0000, 16'h003c};
    logic core_clk, reset, tgl, e, rd_valid, cmd_err, wend, wr_en, rd_en;
    logic [6:0][11:0] code;
    logic [6:0] vld;
    logic [15:0] d, cmd, rd_data;
    logic [7:0] wr_data;
    logic [1:0] sel1, sel2;
    logic [5:0] trim1, trim2;
    logic [8:0] steps1, steps2;
    logic [11:0] otp1, otp2;
    int err_count = 0;
    int check_count = 0;
    int n;
    ctr_host host (.core_clk(core_clk), .pmbus_rd_data(rd_data), .pmbus_rd_valid(rd_valid),
        .pmbus_cmd_err(cmd_err), .pmbus_cmd(cmd), .pmbus_wr_en(wr_en), .pmbus_wr_data(wr_data),
        .pmbus_rd_en(rd_en));
    ctr_readout #(.BASE_WINDOW_CYCLES(BW)) uut (.core_clk(core_clk), .reset(reset),
        .aux_fast_current_code(code[0]), .aux_fast_current_valid(vld[0]),
        .fast_current_sense_a_code(code[1]), .fast_current_sense_a_valid(vld[1]),
        .fast_current_sense_b_code(code[2]), .fast_current_sense_b_valid(vld[2]),
        .precise_current_sense_a_code(code[3]), .precise_current_sense_a_valid(vld[3]),
        .precise_current_sense_b_code(code[4]), .precise_current_sense_b_valid(vld[4]),
        .thermistor_input_one_code(code[5]), .thermistor_input_one_valid(vld[5]),
        .thermistor_input_two_code(code[6] + {11'h000, tgl}), .thermistor_input_two_valid(vld[6]),
        .pmbus_cmd(cmd), .pmbus_wr_en(wr_en), .pmbus_wr_data(wr_data), .pmbus_rd_en(rd_en),
        .pmbus_rd_data(rd_data), .pmbus_rd_valid(rd_valid), .pmbus_cmd_err(cmd_err),
        .thermistor_one_bias_sel(sel1), .thermistor_one_bias_trim(trim1),
        .thermistor_one_bias_steps(steps1), .thermistor_two_bias_sel(sel2),
        .thermistor_two_bias_trim(trim2), .thermistor_two_bias_steps(steps2),
        .thermistor_one_otp_code(otp1), .thermistor_two_otp_code(otp2), .current_window_end(wend));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rdc(input string what, input logic [15:0] c, input logic [15:0] exp);
        host.access(c, 1'b0, 8'h00, d, e);
        chk(what, exp, d);
    endtask : rdc
    task automatic wr(input logic [15:0] c, input logic [7:0] v);
        host.access(c, 1'b1, v, d, e);
    endtask : wr
    task automatic wait_end();
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (wend !== 1'b1 && n < 2000);
    endtask : wait_end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(negedge core_clk) tgl <= ~tgl;
    initial begin
        #(8 * 20000);
        err_count++;
        $display("watchdog expired");
        finish_test();
    end
    initial begin
        {reset, tgl, code, vld} = {1'b1, 1'b0, 84'h0, 7'h00};
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) reset = 1'b0;
        rdc("bias one reset", 16'hfe80, 16'h00e6);
        chk("steps reset", 16'h0126, steps1);
        rdc("rate reset", 16'hfe89, 16'h0000);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].cmd, rows[i].wd);
            rdc("register readback", rows[i].cmd, rows[i].exp);
            if (rows[i].cmd[3] == 1'b0) begin
                chk("steps", rows[i].stp, rows[i].cmd[0] ? steps2 : steps1);
            end
        end
        chk("bias fields", 16'h40ff, {sel1, trim1, sel2, trim2});
        $display("table test done");
        wr(16'hfed7, 8'h55);
        chk("read-only write refused", 16'h0001, e);
        rdc("unmapped read", 16'hfe00, 16'h0000);
        chk("unmapped refused", 16'h0001, e);
        for (int r = 1; r < 4; r++) begin
            wr(16'hfe89, r[7:0]);
            wait_end();
            wait_end();
            chk("refresh period", 16'(BW * (r == 1 ? 5 : r == 2 ? 10 : 20)), 16'(n));
        end
        wr(16'hfe89, 8'h00);
        $display("rate test done");
        code = {12'h45f, 12'hfa0, 12'hfff, 12'h555, 12'h000, 12'hfff, 12'ha00};
        vld = 7'h7f;
        repeat (3 * BW) @(negedge core_clk);
        foreach (adr[i]) begin
            rdc("measurement", adr[i], vex[i]);
        end
        chk("protection code", 16'h0ccd, otp1);
        chk("protection two", 16'h045f, otp2);
        vld = 7'h00;
        repeat (3 * BW) @(negedge core_clk);
        rdc("empty window keeps", 16'hfed8, 16'h045f);
        $display("measurement test done");
        reset = 1'b1;
        repeat (3) @(negedge core_clk);
        reset = 1'b0;
        rdc("bias two after reset", 16'hfe81, 16'h00e6);
        rdc("raw after reset", 16'hfed7, 16'h0000);
        $display("second reset test done");
        finish_test();
    end
endmodule : tb_ctr_readout
